/* hdl/adif_top.sv */
// adif_top: inter-axis feedback deviation monitor and interrupt feeding.
// assumes: feedback positions arrive on clk_i; interrupt inputs are async pins.
`timescale 1ns/1ps
// Behaviour
// - deviation at limit stops interpolation axes
// - deviation check only during linear interpolation
// - monitor enable bit, default off
// - deviation limit 0 to 65535, default 0
// - four-bit mask selects configuration axes 1-4
// - peak deviation held while checking, host-readable
// - memory start commands clear the peak
// - error when monitored axes differ in mode
// - interrupt latches feedback, feeds set amount beyond
// - virtual axes refuse interrupt feeding
// - start by speed, absolute or relative
// - optional error when no interrupt before completion
// - reverse handling follows configured parameter
// - feed amount may exceed one revolution
// - interrupt mask bit in the feed command blocks detection
// - masked interrupts are ignored
// - no interrupt: commanded position is final stop
module adif_top #(
  parameter int unsigned N_AXES = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [adif_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [adif_pkg::DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [adif_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [adif_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [N_AXES-1:0][31:0] fb_pos_i,
  input wire logic [N_AXES-1:0] irq_pin_i,
  output logic interp_stop_o,
  output logic [N_AXES-1:0][31:0] feed_target_o,
  output logic [N_AXES-1:0] feed_target_valid_o,
  output logic [N_AXES-1:0] feed_busy_o,
  output logic error_o
);
  import adif_pkg::*;

  // ==========================================================================
  // elaboration check
  if (N_AXES < 2 || N_AXES > MAX_AXES) begin : g_bad_axes
    $error("adif_top: N_AXES must be 2 to 4");
  end

  // ==========================================================================
  // bus slave
  adif_reg_if reg_if ();

  adif_axil u_axil (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .reg_if(reg_if)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : merge

  // ==========================================================================
  // address decode
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic wr_ctrl;
  logic wr_limit;
  logic wr_axmode;
  logic wr_status;
  logic wr_ax;
  logic [1:0] wr_axis;
  logic [1:0] wr_sub;

  assign wmask = merge(32'h0000_0000, 32'hffff_ffff, reg_if.wr_strb);
  assign wbits = reg_if.wr_data & wmask;
  assign wr_ctrl = reg_if.wr_en && reg_if.wr_addr == OFF_CTRL;
  assign wr_limit = reg_if.wr_en && reg_if.wr_addr == OFF_LIMIT;
  assign wr_axmode = reg_if.wr_en && reg_if.wr_addr == OFF_AXMODE;
  assign wr_status = reg_if.wr_en && reg_if.wr_addr == OFF_STATUS;
  assign wr_ax = reg_if.wr_en && reg_if.wr_addr[7:6] == AX_BLOCK
                 && reg_if.wr_addr[1:0] == 2'h0 && 32'(reg_if.wr_addr[5:4]) < N_AXES;
  assign wr_axis = reg_if.wr_addr[5:4];
  assign wr_sub = reg_if.wr_addr[3:2];
  assign reg_if.wr_ok = wr_ctrl || wr_limit || wr_axmode || wr_status
                        || (wr_ax && wr_sub != AX_TGT);

  // ==========================================================================
  // global configuration
  logic mon_en_r;
  logic [3:0] tmask_r;
  adif_mode_t op_mode_r;
  logic [15:0] limit_r;
  logic [31:0] limit_m;
  logic [7:0] axmode_r;
  logic mem_start_p;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mon_en_r <= RST_MON_EN;
      tmask_r <= RST_MASK;
      op_mode_r <= OP_IDLE;
    end else if (wr_ctrl) begin
      if (reg_if.wr_strb[0]) begin
        mon_en_r <= reg_if.wr_data[CTRL_MON_EN];
        tmask_r <= reg_if.wr_data[CTRL_MASK_LSB+:4];
      end
      if (reg_if.wr_strb[1]) begin
        op_mode_r <= adif_mode_t'(reg_if.wr_data[CTRL_MODE_LSB+:2]);
      end
    end
  end

  assign limit_m = merge({16'h0000, limit_r}, reg_if.wr_data, reg_if.wr_strb);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      limit_r <= RST_LIMIT;
    end else if (wr_limit) begin
      limit_r <= limit_m[15:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      axmode_r <= RST_AXMODE;
    end else if (wr_axmode && reg_if.wr_strb[0]) begin
      axmode_r <= reg_if.wr_data[7:0];
    end
  end

  assign mem_start_p = wr_ctrl && (wbits[CTRL_MEM_START] || wbits[CTRL_MEM_IND]);

  // ==========================================================================
  // inter-axis deviation monitor
  logic [3:0] sel;
  logic [3:0] sel_rot;
  logic mode_mismatch;
  logic check_on;
  logic dev_hit;
  logic [32:0] dev_max;
  logic [31:0] peak_r;
  logic interp_stop_r;
  logic mode_err_r;

  assign sel = tmask_r & 4'((1 << N_AXES) - 1);
  assign sel_rot = sel & axmode_r[AXM_ROT_LSB+:4];
  assign mode_mismatch = sel_rot != 4'h0 && sel_rot != sel;
  assign check_on = mon_en_r && op_mode_r == OP_LIN && !mode_mismatch;

  always_comb begin
    logic [32:0] diff;
    logic [32:0] mag;
    diff = '0;
    mag = '0;
    dev_hit = 1'b0;
    dev_max = '0;
    for (int i = 0; i < N_AXES; i++) begin
      for (int j = i + 1; j < N_AXES; j++) begin
        if (sel[i] && sel[j]) begin
          diff = {fb_pos_i[i][31], fb_pos_i[i]} - {fb_pos_i[j][31], fb_pos_i[j]};
          mag = diff[32] ? 33'(-diff) : diff;
          if (mag > dev_max) begin
            dev_max = mag;
          end
          if (mag >= {17'h0_0000, limit_r}) begin
            dev_hit = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      peak_r <= RST_WORD;
    end else if (mem_start_p) begin
      peak_r <= RST_WORD;
    end else if (check_on && dev_max > {1'b0, peak_r}) begin
      peak_r <= dev_max[32] ? 32'hffff_ffff : dev_max[31:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interp_stop_r <= 1'b0;
    end else if (check_on && dev_hit) begin
      interp_stop_r <= 1'b1;
    end else if (mem_start_p || (wr_status && wbits[ST_DEV_STOP])) begin
      interp_stop_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_err_r <= 1'b0;
    end else if (mon_en_r && op_mode_r == OP_LIN && mode_mismatch) begin
      mode_err_r <= 1'b1;
    end else if (wr_status && wbits[ST_MODE_ERR]) begin
      mode_err_r <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt feeding, one engine per axis
  logic [7:0] fcmd_r [N_AXES];
  logic [31:0] amt_r [N_AXES];
  logic [31:0] pos_r [N_AXES];
  logic [31:0] tgt_r [N_AXES];
  logic [N_AXES-1:0] tgt_vld_r;
  logic [N_AXES-1:0] busy_r;
  logic [N_AXES-1:0] feeding;
  logic [N_AXES-1:0] undet_r;
  logic [N_AXES-1:0] virt_err_r;
  logic [N_AXES-1:0] irq_s1_r;
  logic [N_AXES-1:0] irq_s2_r;
  logic [N_AXES-1:0] irq_s3_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      irq_s3_r <= '0;
    end else begin
      irq_s1_r <= irq_pin_i;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
    end
  end

  for (genvar a = 0; a < N_AXES; a++) begin : g_axis
    adif_feed_t st_r;
    logic wr_here;
    logic start_p;
    logic irq_acc;
    logic dir_neg;
    logic [31:0] eff_amt;
    logic [31:0] rel_tgt;
    logic arrived;

    assign wr_here = wr_ax && wr_axis == 2'(a);
    assign start_p = wr_here && wr_sub == AX_CMD && reg_if.wr_strb[0] && wbits[FC_SPEC]
                     && (wbits[FC_SPEED] || wbits[FC_ABS] || wbits[FC_REL]);
    assign irq_acc = irq_s2_r[a] && !irq_s3_r[a] && st_r == FD_WAIT
                     && !fcmd_r[a][FC_MASK];
    assign dir_neg = fcmd_r[a][FC_SPEED] ? fcmd_r[a][FC_DIR_NEG]
                     : $signed(tgt_r[a]) < $signed(fb_pos_i[a]);
    assign eff_amt = dir_neg ? 32'(-amt_r[a]) : amt_r[a];
    assign rel_tgt = fb_pos_i[a] + pos_r[a];
    assign arrived = tgt_vld_r[a] && fb_pos_i[a] == tgt_r[a];
    assign feeding[a] = st_r == FD_FEED;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        fcmd_r[a] <= RST_FCMD;
        amt_r[a] <= RST_WORD;
        pos_r[a] <= RST_WORD;
      end else if (wr_here) begin
        if (wr_sub == AX_CMD && reg_if.wr_strb[0]) begin
          fcmd_r[a] <= reg_if.wr_data[7:0];
        end
        if (wr_sub == AX_AMT) begin
          amt_r[a] <= merge(amt_r[a], reg_if.wr_data, reg_if.wr_strb);
        end
        if (wr_sub == AX_POS) begin
          pos_r[a] <= merge(pos_r[a], reg_if.wr_data, reg_if.wr_strb);
        end
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        st_r <= FD_IDLE;
        tgt_r[a] <= RST_WORD;
        tgt_vld_r[a] <= 1'b0;
      end else begin
        unique case (st_r)
          FD_IDLE: begin
            if (start_p && !axmode_r[AXM_VIRT_LSB+a]) begin
              st_r <= FD_WAIT;
              if (wbits[FC_ABS]) begin
                tgt_r[a] <= pos_r[a];
                tgt_vld_r[a] <= 1'b1;
              end else if (wbits[FC_REL]) begin
                tgt_r[a] <= rel_tgt;
                tgt_vld_r[a] <= 1'b1;
              end else begin
                tgt_vld_r[a] <= 1'b0;
              end
            end
          end
          FD_WAIT: begin
            if (irq_acc) begin
              st_r <= FD_FEED;
              tgt_vld_r[a] <= 1'b1;
              if (amt_r[a][31] && fcmd_r[a][FC_REV_STOP]) begin
                tgt_r[a] <= fb_pos_i[a];
              end else begin
                tgt_r[a] <= fb_pos_i[a] + eff_amt;
              end
            end else if (arrived) begin
              st_r <= FD_IDLE;
            end
          end
          FD_FEED: begin
            if (arrived) begin
              st_r <= FD_IDLE;
            end
          end
          default: begin
            st_r <= FD_IDLE;
          end
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        undet_r[a] <= 1'b0;
      end else if (st_r == FD_WAIT && !irq_acc && arrived && fcmd_r[a][FC_ERR_EN]) begin
        undet_r[a] <= 1'b1;
      end else if (wr_status && wbits[ST_UNDET_LSB+a]) begin
        undet_r[a] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        virt_err_r[a] <= 1'b0;
      end else if (start_p && axmode_r[AXM_VIRT_LSB+a]) begin
        virt_err_r[a] <= 1'b1;
      end else if (wr_status && wbits[ST_VIRT_LSB+a]) begin
        virt_err_r[a] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        busy_r[a] <= 1'b0;
      end else begin
        busy_r[a] <= st_r != FD_IDLE;
      end
    end
  end

  // ==========================================================================
  // outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interp_stop_o <= 1'b0;
      feed_target_o <= '0;
      feed_target_valid_o <= '0;
      feed_busy_o <= '0;
      error_o <= 1'b0;
    end else begin
      interp_stop_o <= interp_stop_r;
      for (int k = 0; k < N_AXES; k++) begin
        feed_target_o[k] <= tgt_r[k];
      end
      feed_target_valid_o <= tgt_vld_r;
      feed_busy_o <= busy_r;
      error_o <= mode_err_r || (|undet_r) || (|virt_err_r);
    end
  end

  // ==========================================================================
  // read mux
  always_comb begin
    logic [31:0] st;
    logic [1:0] ax;
    st = '0;
    ax = reg_if.rd_addr[5:4];
    st[ST_DEV_STOP] = interp_stop_r;
    st[ST_MODE_ERR] = mode_err_r;
    st[ST_UNDET_LSB+:N_AXES] = undet_r;
    st[ST_VIRT_LSB+:N_AXES] = virt_err_r;
    st[ST_BUSY_LSB+:N_AXES] = busy_r;
    st[ST_FEED_LSB+:N_AXES] = feeding;
    reg_if.rd_data = '0;
    reg_if.rd_ok = reg_if.rd_addr[1:0] == 2'h0;
    if (reg_if.rd_addr == OFF_CTRL) begin
      reg_if.rd_data[CTRL_MON_EN] = mon_en_r;
      reg_if.rd_data[CTRL_MASK_LSB+:4] = tmask_r;
      reg_if.rd_data[CTRL_MODE_LSB+:2] = op_mode_r;
    end else if (reg_if.rd_addr == OFF_LIMIT) begin
      reg_if.rd_data[15:0] = limit_r;
    end else if (reg_if.rd_addr == OFF_AXMODE) begin
      reg_if.rd_data[7:0] = axmode_r;
    end else if (reg_if.rd_addr == OFF_PEAK) begin
      reg_if.rd_data = peak_r;
    end else if (reg_if.rd_addr == OFF_STATUS) begin
      reg_if.rd_data = st;
    end else if (reg_if.rd_addr[7:6] == AX_BLOCK && 32'(ax) < N_AXES) begin
      unique case (reg_if.rd_addr[3:2])
        AX_CMD: reg_if.rd_data[7:0] = fcmd_r[ax];
        AX_AMT: reg_if.rd_data = amt_r[ax];
        AX_POS: reg_if.rd_data = pos_r[ax];
        AX_TGT: reg_if.rd_data = tgt_r[ax];
      endcase
    end else begin
      reg_if.rd_ok = 1'b0;
    end
  end

endmodule : adif_top

/* hdl/adif_pkg.sv */
// adif_pkg: constants, register map, field positions and types of the
// axis deviation monitor and interrupt feeding block.
// assumes: a 32-bit AXI4-Lite register bus, at most four axes.
package adif_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned MAX_AXES = 4;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LIMIT = 8'h04;
  localparam logic [7:0] OFF_AXMODE = 8'h08;
  localparam logic [7:0] OFF_PEAK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // per-axis block: addr[7:6] selects, addr[5:4] is the axis, addr[3:2] the word
  localparam logic [1:0] AX_BLOCK = 2'h1;
  localparam logic [1:0] AX_CMD = 2'h0;
  localparam logic [1:0] AX_AMT = 2'h1;
  localparam logic [1:0] AX_POS = 2'h2;
  localparam logic [1:0] AX_TGT = 2'h3;

  // ==========================================================================
  // field positions
  localparam int unsigned CTRL_MON_EN = 0;
  localparam int unsigned CTRL_MEM_START = 1;
  localparam int unsigned CTRL_MEM_IND = 2;
  localparam int unsigned CTRL_MASK_LSB = 4;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam int unsigned AXM_ROT_LSB = 0;
  localparam int unsigned AXM_VIRT_LSB = 4;
  localparam int unsigned FC_SPEC = 0;
  localparam int unsigned FC_SPEED = 1;
  localparam int unsigned FC_ABS = 2;
  localparam int unsigned FC_REL = 3;
  localparam int unsigned FC_MASK = 4;
  localparam int unsigned FC_ERR_EN = 5;
  localparam int unsigned FC_REV_STOP = 6;
  localparam int unsigned FC_DIR_NEG = 7;
  localparam int unsigned ST_DEV_STOP = 0;
  localparam int unsigned ST_MODE_ERR = 1;
  localparam int unsigned ST_UNDET_LSB = 4;
  localparam int unsigned ST_VIRT_LSB = 8;
  localparam int unsigned ST_BUSY_LSB = 12;
  localparam int unsigned ST_FEED_LSB = 16;

  // ==========================================================================
  // reset values
  localparam logic RST_MON_EN = 1'b0;
  localparam logic [15:0] RST_LIMIT = 16'h0000;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [7:0] RST_AXMODE = 8'h00;
  localparam logic [7:0] RST_FCMD = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_LIN = 2'b01,
    OP_OTHER = 2'b10,
    OP_OTHER2 = 2'b11
  } adif_mode_t;

  typedef enum logic [1:0] {
    FD_IDLE = 2'b00,
    FD_WAIT = 2'b01,
    FD_FEED = 2'b10
  } adif_feed_t;

  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } adif_resp_t;

endpackage : adif_pkg

/* hdl/adif_reg_if.sv */
// adif_reg_if: register access strobes between the bus slave and the core.
// assumes: both ends on the same clock; rd_data and oks answer in-cycle.
`timescale 1ns/1ps
interface adif_reg_if;
  import adif_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic rd_ok;
  modport axil(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_ok, rd_data, rd_ok);
  modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               output wr_ok, rd_data, rd_ok);
endinterface : adif_reg_if

/* hdl/adif_axil.sv */
// adif_axil: AXI4-Lite slave turning bus transfers into register strobes.
// assumes: one write and one read under way at a time, per AXI4-Lite.
`timescale 1ns/1ps
module adif_axil (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [adif_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [adif_pkg::DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [adif_pkg::ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [adif_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  adif_reg_if.axil reg_if
);
  import adif_pkg::*;

  logic aw_have_r;
  logic w_have_r;
  logic ar_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [ADDR_W-1:0] araddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  logic do_rd;

  assign do_wr = aw_have_r && w_have_r && !bvalid_o;
  assign do_rd = ar_have_r && !rvalid_o;
  assign reg_if.wr_en = do_wr;
  assign reg_if.wr_addr = awaddr_r;
  assign reg_if.wr_data = wdata_r;
  assign reg_if.wr_strb = wstrb_r;
  assign reg_if.rd_en = do_rd;
  assign reg_if.rd_addr = araddr_r;

  // ==========================================================================
  // write path
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_have_r <= 1'b1;
        awaddr_r <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_have_r <= 1'b1;
        wdata_r <= wdata_i;
        wstrb_r <= wstrb_i;
        wready_o <= 1'b0;
      end
      if (do_wr) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= reg_if.wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // read path
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arready_o <= 1'b1;
      ar_have_r <= 1'b0;
      araddr_r <= '0;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= RESP_OKAY;
    end else begin
      if (arvalid_i && arready_o) begin
        ar_have_r <= 1'b1;
        araddr_r <= araddr_i;
        arready_o <= 1'b0;
      end
      if (do_rd) begin
        ar_have_r <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= reg_if.rd_data;
        rresp_o <= reg_if.rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

endmodule : adif_axil

/* tb/adif_top_monitor.sv */
// adif_top_monitor: bus handshake and sticky flag checks on adif_top
// assumes: one clock domain, bound to every adif_top
`timescale 1ns/1ps
module adif_top_monitor (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [adif_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic interp_stop_o,
  input wire logic error_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rresp_o))
    else $error("rresp moved");
  a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken early");
  a_b_late: assert property ($rose(s_axi_bvalid_o) |-> !$past(s_axi_awready_o))
    else $error("bvalid too soon");
  a_r_timing: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
    else $error("read answer late");
  a_rd_misalign: assert property (s_axi_arready_o && s_axi_arvalid_i
    && s_axi_araddr_i[1:0] != 2'h0 |-> ##2 s_axi_rresp_o == 2'h2)
    else $error("misaligned read accepted");
  a_stop_sticky: assert property (interp_stop_o |=>
    interp_stop_o || s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("stop lost");
  a_err_sticky: assert property (error_o |=>
    error_o || s_axi_bvalid_o || $past(s_axi_bvalid_o)) else $error("error lost");
endmodule : adif_top_monitor
bind adif_top adif_top_monitor u_adif_top_monitor (.*);

/* tb/adif_drive_model.sv */
// adif_drive_model: servo drives, feedback walks one unit a clock
// assumes: bench loads positions, adif_top gives targets
`timescale 1ns/1ps
module adif_drive_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [3:0][31:0] load_pos_i,
  input wire logic [3:0][31:0] target_i,
  input wire logic [3:0] go_i,
  output logic [3:0][31:0] fb_pos_o = '0
);
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (load_i) begin
        fb_pos_o[i] <= load_pos_i[i];
      end else if (go_i[i] && fb_pos_o[i] != target_i[i]) begin
        fb_pos_o[i] <= fb_pos_o[i] + ($signed(target_i[i] - fb_pos_o[i]) > 0 ? 1 : -1);
      end
    end
  end
endmodule : adif_drive_model

/* tb/tb_axis_deviation_interrupt_feed.sv */
// tb_axis_deviation_interrupt_feed: register level tests of adif_top
// assumes: adif_drive_model plays the drives
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %0h not %0h", $time, g, e); end end
module tb_axis_deviation_interrupt_feed;
  logic clk = 0, rst_n = 0, ld = 1;
  logic [7:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, rdt;
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wrd, bv, arr, rv, stp, err;
  logic [1:0] br, rr;
  logic [3:0] irq = 0, tv, bsy;
  logic [3:0][31:0] fb, tg;
  logic [3:0][31:0] sp = {32'd0, 32'd1000, 32'd100, 32'd0};
  int n_fail = 0, checks = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  adif_top u_adif_top (.clk_i(clk), .arst_n_i(rst_n), .s_axi_awaddr_i(aa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .fb_pos_i(fb), .irq_pin_i(irq), .interp_stop_o(stp), .feed_target_o(tg),
    .feed_target_valid_o(tv), .feed_busy_o(bsy), .error_o(err));
  adif_drive_model u_adif_drive_model (.clk_i(clk), .load_i(ld), .load_pos_i(sp),
    .target_i(tg), .go_i(tv & bsy), .fb_pos_o(fb));
  task automatic complete_run;
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    {aa, wd, awv, wv} <= {a, d, 2'b11};
    forever begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      if (bv && bre) break;
      bre <= bv;
    end
    bre <= 0;
    `CHK(br, e)
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    {ra, arv} <= {a, 1'b1};
    forever begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv && rre) break;
      rre <= rv;
    end
    rre <= 0;
    `CHK({rdt, rr}, {e, er})
  endtask : rd
  task automatic setp(input logic [31:0] p);
    @(posedge clk);
    {sp[1], ld} <= {p, 1'b1};
    @(posedge clk);
    ld <= 0;
    repeat (4) @(posedge clk);
  endtask : setp
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    setp(100);
    rd(8'h00, 0, 0);
    rd(8'h04, 0, 0);
    rd(8'h02, 0, 2);
    wr(8'h6c, 1, 2);
    wr(8'h04, 100, 0);
    wr(8'h00, 32'h231, 0);
    setp(100);
    `CHK(stp, 1'b0)
    wr(8'h00, 32'h130, 0);
    setp(100);
    `CHK(stp, 1'b0)
    wr(8'h00, 32'h131, 0);
    setp(100);
    `CHK(stp, 1'b1)
    setp(50);
    rd(8'h10, 100, 0);
    for (int i = 1; i < 3; i++) begin
      setp(40);
      setp(0);
      wr(8'h00, 32'h131 | (1 << i), 0);
      rd(8'h10, 0, 0);
    end
    wr(8'h14, 1, 0);
    setp(50);
    `CHK(stp, 1'b0)
    wr(8'h08, 1, 0);
    setp(50);
    `CHK(err, 1'b1)
    wr(8'h08, 0, 0);
    wr(8'h00, 0, 0);
    wr(8'h14, 32'hff3, 0);
    wr(8'h64, 50, 0);
    wr(8'h60, 3, 0);
    wr(8'h50, 32'h13, 0);
    irq <= 4'h6;
    repeat (8) @(posedge clk);
    irq <= 0;
    `CHK({tg[2], tv}, {32'd1050, 4'h4})
    repeat (60) @(posedge clk);
    `CHK(bsy[2], 1'b0)
    wr(8'h64, 32'hffff_fff9, 0);
    wr(8'h60, 32'h43, 0);
    setp(50);
    irq <= 4'h4;
    repeat (8) @(posedge clk);
    irq <= 0;
    `CHK(tg[2], 32'd1000)
    wr(8'h48, 20, 0);
    wr(8'h40, 32'h25, 0);
    repeat (30) @(posedge clk);
    `CHK({tg[0], err}, {32'd20, 1'b1})
    wr(8'h14, 32'hff0, 0);
    wr(8'h08, 32'h80, 0);
    wr(8'h70, 9, 0);
    setp(50);
    `CHK({bsy[3], err}, 2'b01)
    wr(8'h08, 0, 0);
    wr(8'h78, 5, 0);
    wr(8'h70, 9, 0);
    setp(50);
    `CHK(tg[3], 32'd5)
    complete_run();
  end
endmodule : tb_axis_deviation_interrupt_feed
